// ### logic/alrss_pkg.sv
// Purpose: Shared constants and types for the auxiliary line run and shear sequencer.
// Assumes: A 40 MHz system clock and a 32-bit AXI4-Lite register bus.
// Notes: Dwell figures are in one-millisecond steps.
package alrss_pkg;

	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned DWELL_STEP_NS = 1000000;
	localparam int unsigned DWELL_STEP_CYCLES = DWELL_STEP_NS / CLK_PERIOD_NS;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned COMPLETE_TIMEOUT_S = 10;
	localparam int unsigned COMPLETE_TIMEOUT_STEPS = COMPLETE_TIMEOUT_S * MS_PER_S;

	localparam int unsigned DWELL_W = 14;
	localparam logic [13:0] DWELL_MAX = 14'h270F;
	localparam logic [7:0] UNIT_BASE = 8'h1E;
	localparam logic [3:0] DEVICE_BASE = 4'h1;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DWELL_DOWN = 8'h04;
	localparam logic [7:0] OFS_DWELL_UP = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFS_UNIT = 8'h18;
	localparam logic [7:0] OFS_POSITION = 8'h1C;
	localparam logic [7:0] OFS_POST_DELAY = 8'h20;

	localparam int unsigned CTRL_JOB_READY = 0;
	localparam int unsigned CTRL_MOTION_RUN = 1;
	localparam int unsigned CTRL_FEED_TO_STOP = 2;
	localparam int unsigned CTRL_BOOST_EN = 3;
	localparam int unsigned CTRL_UP_EN = 4;
	localparam int unsigned CTRL_JOG_FWD = 5;
	localparam int unsigned CTRL_JOG_REV = 6;
	localparam int unsigned CTRL_SLOW_SEL = 7;
	localparam int unsigned CTRL_DRIVE_EN = 8;
	localparam int unsigned CTRL_FIRE = 12;
	localparam int unsigned CTRL_BATCH_HALT = 13;
	localparam int unsigned CTRL_ERR_CLEAR = 14;
	localparam int unsigned CTRL_W = 9;

	localparam logic [8:0] CTRL_RST = 9'h000;
	localparam logic [13:0] DWELL_DOWN_RST = 14'h0064;
	localparam logic [13:0] DWELL_UP_RST = 14'h0064;
	localparam logic [13:0] POST_DELAY_RST = 14'h0000;

	localparam int unsigned IRQ_RUN_START = 0;
	localparam int unsigned IRQ_RUN_DROP = 1;
	localparam int unsigned IRQ_ESTOP = 2;
	localparam int unsigned IRQ_SHEAR_DONE = 3;
	localparam int unsigned IRQ_TIMEOUT = 4;
	localparam int unsigned IRQ_W = 5;
	localparam logic [4:0] IRQ_MASK_RST = 5'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		LINE_HALT = 3'h0,
		LINE_RUN_FAST = 3'h1,
		LINE_RUN_SLOW = 3'h3,
		LINE_JOG_FWD = 3'h2,
		LINE_JOG_REV = 3'h6,
		LINE_ESTOP = 3'h4
	} alrss_line_t;

	typedef enum logic [1:0] {
		SHEAR_IDLE = 2'h0,
		SHEAR_DOWN = 2'h1,
		SHEAR_UP = 2'h3
	} alrss_shear_t;

endpackage : alrss_pkg

// ### logic/alrss_in_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for machine inputs.
// Assumes: Inputs are slow contacts from outside the clock domain.
// Notes: The output moves only when the second and third stages agree.
`timescale 1ns/1ps
module alrss_in_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			always_ff @(posedge clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					q_out[i] <= 1'b0;
				end else begin
					s1_q <= d_in[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						q_out[i] <= s3_q;
					end
				end
			end
		end
	endgenerate
endmodule : alrss_in_sync

// ### logic/alrss_dwell_timer.sv
// Purpose: Millisecond dwell timer with optional early end and zero-dwell hold.
// Assumes: start_in is honoured only while idle.
// Notes: A zero duration with early end allowed waits for complete or times out.
`timescale 1ns/1ps
module alrss_dwell_timer #(
	parameter int unsigned STEP_CYCLES = 40000,
	parameter int unsigned TIMEOUT_STEPS = 10000
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic start_in,
	input wire logic [13:0] dur_in,
	input wire logic early_in,
	input wire logic complete_in,
	output logic active_out,
	output logic done_out,
	output logic timeout_out
);
	logic [31:0] pre_q;
	logic [31:0] cnt_q;
	logic [13:0] dur_q;
	logic early_q;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			active_out <= 1'b0;
			done_out <= 1'b0;
			timeout_out <= 1'b0;
			pre_q <= 32'h00000000;
			cnt_q <= 32'h00000000;
			dur_q <= 14'h0000;
			early_q <= 1'b0;
		end else begin
			done_out <= 1'b0;
			timeout_out <= 1'b0;
			if (start_in && !active_out) begin
				active_out <= 1'b1;
				pre_q <= 32'h00000000;
				cnt_q <= 32'h00000000;
				dur_q <= dur_in;
				early_q <= early_in;
			end else if (active_out) begin
				if (early_q && complete_in) begin
					active_out <= 1'b0;
					done_out <= 1'b1;
				end else if (dur_q == 14'h0000 && !early_q) begin
					active_out <= 1'b0;
					done_out <= 1'b1;
				end else if (dur_q == 14'h0000 && cnt_q == 32'(TIMEOUT_STEPS)) begin
					active_out <= 1'b0;
					timeout_out <= 1'b1;
				end else if (dur_q != 14'h0000 && cnt_q == 32'(dur_q)) begin
					active_out <= 1'b0;
					done_out <= 1'b1;
				end else if (pre_q == 32'(STEP_CYCLES - 1)) begin
					pre_q <= 32'h00000000;
					cnt_q <= cnt_q + 32'h00000001;
				end else begin
					pre_q <= pre_q + 32'h00000001;
				end
			end
		end
	end
endmodule : alrss_dwell_timer

// ### logic/alrss_sequencer.sv
// Purpose: Run, line motion and shear sequencing for a display-less auxiliary controller.
// Assumes: Machine inputs are dry contacts; the master programs jobs over AXI4-Lite.
// Notes: Position keeps counting through an emergency stop while clocked.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - Unit number thirty plus three selector switches.
// - Run starts only with job, no error.
// - Run holds until batch halt, halt or dwell timeout.
// - Line-motion run choice: run follows fast.
// - Forward, slow, reverse, run per state.
// - Emergency stop drops run mode.
// - Position keeps tracking through emergency stop.
// - Flying-cut or feed-to-stop selects shear outputs.
// - Down and up dwells in millisecond steps.
// - Shear complete ends down dwell early.
// - Up dwell always runs its full time.
// - Drive enable open shuts the drive.
// - Shear firing is not gated by run.
// - Zero down dwell holds, blocks restart, ten-second timeout.
module alrss_sequencer #(
	parameter int unsigned STEP_CYCLES = alrss_pkg::DWELL_STEP_CYCLES,
	parameter int unsigned TIMEOUT_STEPS = alrss_pkg::COMPLETE_TIMEOUT_STEPS
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic run_request_relay_in,
	input wire logic halt_in,
	input wire logic estop_closed_in,
	input wire logic shear_complete_in,
	input wire logic pos_pulse_in,
	input wire logic pos_reverse_in,
	input wire logic unit_select_bit0_in,
	input wire logic unit_select_bit1_in,
	input wire logic unit_select_bit2_in,
	output logic run_out,
	output logic forward_out,
	output logic slow_out,
	output logic reverse_out,
	output logic shear_down_out,
	output logic shear_up_out,
	output logic die_boost_out,
	output logic drive_enable_out,
	output logic irq_out
);
	import alrss_pkg::*;

	logic [8:0] sync_q;
	logic run_in_s;
	logic halt_s;
	logic estop_ok;
	logic complete_s;
	logic pulse_s;
	logic rev_s;
	logic [2:0] unit_sel;
	logic run_prev_q;
	logic pulse_prev_q;
	logic [CTRL_W-1:0] ctrl_q;
	logic [13:0] dwell_down_q;
	logic [13:0] dwell_up_q;
	logic [13:0] post_delay_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] events;
	logic [31:0] position_q;
	logic err_q;
	alrss_line_t line_q;
	alrss_line_t line_d;
	alrss_shear_t shear_q;
	alrss_shear_t shear_d;
	logic wr_en;
	logic [31:0] wr_data;
	logic rd_clr;
	logic fire;
	logic batch_halt;
	logic err_clear;
	logic run_start;
	logic run_stop;
	logic restart_block;
	logic tmr_start;
	logic tmr_active;
	logic tmr_done;
	logic tmr_timeout;
	logic post_start;
	logic post_active;
	logic run_d;
	logic [7:0] unit_num;
	logic [3:0] device_num;
	logic [31:0] status_w;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic wr_ok;

	alrss_in_sync #(
		.W(9)
	) u_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.d_in({unit_select_bit2_in, unit_select_bit1_in, unit_select_bit0_in, pos_reverse_in,
			pos_pulse_in, shear_complete_in, estop_closed_in, halt_in, run_request_relay_in}),
		.q_out(sync_q)
	);

	assign run_in_s = sync_q[0];
	assign halt_s = sync_q[1];
	assign estop_ok = sync_q[2];
	assign complete_s = sync_q[3];
	assign pulse_s = sync_q[4];
	assign rev_s = sync_q[5];
	assign unit_sel = sync_q[8:6];

	assign unit_num = UNIT_BASE + {5'h00, unit_sel};
	assign device_num = DEVICE_BASE + {1'b0, unit_sel};

	// Software strobes come from the committed write, not from the raw bus.
	assign wr_en = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
	always_comb begin
		wr_data = 32'h00000000;
		for (int b = 0; b < 4; b++) begin
			wr_data[8*b +: 8] = wdata_q[8*b +: 8] & {8{wstrb_q[b]}};
		end
	end
	assign fire = wr_en && awaddr_q == OFS_CTRL && wr_data[CTRL_FIRE];
	assign batch_halt = wr_en && awaddr_q == OFS_CTRL && wr_data[CTRL_BATCH_HALT];
	assign err_clear = wr_en && awaddr_q == OFS_CTRL && wr_data[CTRL_ERR_CLEAR];

	// A zero down dwell or a post-shear delay keeps the line from restarting.
	assign restart_block = (shear_q == SHEAR_DOWN && dwell_down_q == 14'h0000) || post_active;
	assign run_start = run_in_s && !run_prev_q && ctrl_q[CTRL_JOB_READY] && !err_q && estop_ok
		&& !halt_s && !restart_block && !tmr_timeout;
	assign run_stop = halt_s || batch_halt || tmr_timeout;

	always_comb begin
		line_d = line_q;
		unique case (line_q)
			LINE_HALT: begin
				if (!estop_ok) begin
					line_d = LINE_ESTOP;
				end else if (run_start) begin
					line_d = ctrl_q[CTRL_SLOW_SEL] ? LINE_RUN_SLOW : LINE_RUN_FAST;
				end else if (ctrl_q[CTRL_JOG_FWD]) begin
					line_d = LINE_JOG_FWD;
				end else if (ctrl_q[CTRL_JOG_REV]) begin
					line_d = LINE_JOG_REV;
				end
			end
			LINE_RUN_FAST, LINE_RUN_SLOW: begin
				if (!estop_ok) begin
					line_d = LINE_ESTOP;
				end else if (run_stop) begin
					line_d = LINE_HALT;
				end else begin
					line_d = ctrl_q[CTRL_SLOW_SEL] ? LINE_RUN_SLOW : LINE_RUN_FAST;
				end
			end
			LINE_JOG_FWD: begin
				if (!estop_ok) begin
					line_d = LINE_ESTOP;
				end else if (!ctrl_q[CTRL_JOG_FWD]) begin
					line_d = LINE_HALT;
				end
			end
			LINE_JOG_REV: begin
				if (!estop_ok) begin
					line_d = LINE_ESTOP;
				end else if (!ctrl_q[CTRL_JOG_REV]) begin
					line_d = LINE_HALT;
				end
			end
			LINE_ESTOP: begin
				if (estop_ok) begin
					line_d = LINE_HALT;
				end
			end
			default: begin
				line_d = LINE_HALT;
			end
		endcase
	end

	// The run choice makes run track fast motion only.
	always_comb begin
		if (ctrl_q[CTRL_MOTION_RUN]) begin
			run_d = line_d == LINE_RUN_FAST;
		end else begin
			run_d = line_d == LINE_RUN_FAST || line_d == LINE_RUN_SLOW;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			line_q <= LINE_HALT;
			run_prev_q <= 1'b0;
			run_out <= 1'b0;
			forward_out <= 1'b0;
			slow_out <= 1'b0;
			reverse_out <= 1'b0;
		end else begin
			line_q <= line_d;
			run_prev_q <= run_in_s;
			run_out <= run_d;
			forward_out <= line_d == LINE_RUN_FAST || line_d == LINE_RUN_SLOW
				|| line_d == LINE_JOG_FWD;
			slow_out <= line_d != LINE_RUN_FAST;
			reverse_out <= line_d == LINE_JOG_REV;
		end
	end

	// Firing is independent of the line state so targets still cut while coasting.
	assign tmr_start = (shear_q == SHEAR_IDLE && fire) || (shear_q == SHEAR_DOWN && tmr_done);

	always_comb begin
		shear_d = shear_q;
		unique case (shear_q)
			SHEAR_IDLE: begin
				if (fire) begin
					shear_d = SHEAR_DOWN;
				end
			end
			SHEAR_DOWN: begin
				if (tmr_done) begin
					shear_d = SHEAR_UP;
				end else if (tmr_timeout) begin
					shear_d = SHEAR_IDLE;
				end
			end
			SHEAR_UP: begin
				if (tmr_done) begin
					shear_d = SHEAR_IDLE;
				end
			end
			default: begin
				shear_d = SHEAR_IDLE;
			end
		endcase
	end

	alrss_dwell_timer #(
		.STEP_CYCLES(STEP_CYCLES),
		.TIMEOUT_STEPS(TIMEOUT_STEPS)
	) u_dwell (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.start_in(tmr_start),
		.dur_in(shear_q == SHEAR_IDLE ? dwell_down_q : dwell_up_q),
		.early_in(shear_q == SHEAR_IDLE),
		.complete_in(complete_s),
		.active_out(tmr_active),
		.done_out(tmr_done),
		.timeout_out(tmr_timeout)
	);

	assign post_start = shear_q == SHEAR_UP && tmr_done && !ctrl_q[CTRL_MOTION_RUN]
		&& post_delay_q != 14'h0000;

	alrss_dwell_timer #(
		.STEP_CYCLES(STEP_CYCLES),
		.TIMEOUT_STEPS(TIMEOUT_STEPS)
	) u_post (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.start_in(post_start),
		.dur_in(post_delay_q),
		.early_in(1'b0),
		.complete_in(1'b0),
		.active_out(post_active),
		.done_out(),
		.timeout_out()
	);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			shear_q <= SHEAR_IDLE;
			shear_down_out <= 1'b0;
			shear_up_out <= 1'b0;
			die_boost_out <= 1'b0;
		end else begin
			shear_q <= shear_d;
			shear_down_out <= shear_d == SHEAR_DOWN;
			shear_up_out <= shear_d == SHEAR_UP && ctrl_q[CTRL_UP_EN];
			die_boost_out <= shear_d == SHEAR_DOWN && ctrl_q[CTRL_BOOST_EN]
				&& !ctrl_q[CTRL_FEED_TO_STOP];
		end
	end

	// Set wins over clear so a timeout in the clearing cycle is kept.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			err_q <= 1'b0;
			drive_enable_out <= 1'b0;
		end else begin
			err_q <= (err_q && !err_clear) || tmr_timeout;
			drive_enable_out <= ctrl_q[CTRL_DRIVE_EN] && estop_ok && !err_q;
		end
	end

	// Counting does not look at the line state, so position survives a stop.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pulse_prev_q <= 1'b0;
			position_q <= 32'h00000000;
		end else begin
			pulse_prev_q <= pulse_s;
			if (pulse_s && !pulse_prev_q) begin
				position_q <= rev_s ? position_q - 32'h00000001 : position_q + 32'h00000001;
			end
		end
	end

	assign events[IRQ_RUN_START] = line_q == LINE_HALT && (line_d == LINE_RUN_FAST
		|| line_d == LINE_RUN_SLOW);
	assign events[IRQ_RUN_DROP] = run_out && !run_d;
	assign events[IRQ_ESTOP] = line_q != LINE_ESTOP && line_d == LINE_ESTOP;
	assign events[IRQ_SHEAR_DONE] = shear_q == SHEAR_UP && tmr_done;
	assign events[IRQ_TIMEOUT] = tmr_timeout;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_stat_q <= 5'h00;
			irq_out <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~{IRQ_W{rd_clr}}) | events;
			irq_out <= |(irq_stat_q & irq_mask_q);
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_q <= CTRL_RST;
			dwell_down_q <= DWELL_DOWN_RST;
			dwell_up_q <= DWELL_UP_RST;
			post_delay_q <= POST_DELAY_RST;
			irq_mask_q <= IRQ_MASK_RST;
		end else if (wr_en) begin
			unique case (awaddr_q)
				OFS_CTRL: ctrl_q <= wr_data[CTRL_W-1:0];
				OFS_DWELL_DOWN: dwell_down_q <= wr_data[13:0] > DWELL_MAX ? DWELL_MAX
					: wr_data[13:0];
				OFS_DWELL_UP: dwell_up_q <= wr_data[13:0] > DWELL_MAX ? DWELL_MAX
					: wr_data[13:0];
				OFS_POST_DELAY: post_delay_q <= wr_data[13:0] > DWELL_MAX ? DWELL_MAX
					: wr_data[13:0];
				OFS_IRQ_MASK: irq_mask_q <= wr_data[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		unique case (awaddr_q)
			OFS_CTRL, OFS_DWELL_DOWN, OFS_DWELL_UP, OFS_IRQ_MASK, OFS_POST_DELAY: wr_ok = 1'b1;
			OFS_STATUS, OFS_IRQ_STAT, OFS_UNIT, OFS_POSITION: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// Address and data are caught separately and committed once both are held.
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awready_out && s_axi_awvalid_in) begin
				s_axi_awready_out <= 1'b0;
				awaddr_q <= s_axi_awaddr_in;
			end
			if (s_axi_wready_out && s_axi_wvalid_in) begin
				s_axi_wready_out <= 1'b0;
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
			end
			if (wr_en) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out <= 1'b1;
			end
		end
	end

	assign status_w = {16'h0000, restart_block, drive_enable_out, die_boost_out, shear_up_out,
		shear_down_out, reverse_out, slow_out, forward_out, run_out, estop_ok, err_q,
		shear_q, line_q};

	always_comb begin
		rd_ok = 1'b1;
		unique case (s_axi_araddr_in)
			OFS_CTRL: rd_data = {23'h000000, ctrl_q};
			OFS_DWELL_DOWN: rd_data = {18'h00000, dwell_down_q};
			OFS_DWELL_UP: rd_data = {18'h00000, dwell_up_q};
			OFS_STATUS: rd_data = status_w;
			OFS_IRQ_STAT: rd_data = {27'h0000000, irq_stat_q};
			OFS_IRQ_MASK: rd_data = {27'h0000000, irq_mask_q};
			OFS_UNIT: rd_data = {17'h00000, unit_sel, device_num, unit_num};
			OFS_POSITION: rd_data = position_q;
			OFS_POST_DELAY: rd_data = {18'h00000, post_delay_q};
			default: begin
				rd_data = 32'h00000000;
				rd_ok = 1'b0;
			end
		endcase
	end

	assign rd_clr = s_axi_arready_out && s_axi_arvalid_in && s_axi_araddr_in == OFS_IRQ_STAT;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= RESP_OKAY;
		end else if (s_axi_arready_out && s_axi_arvalid_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_data;
			s_axi_rresp_out <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end

endmodule : alrss_sequencer

// ### verification/alrss_asserts.sv
// Purpose: Port checks for the run and shear sequencer.
// Assumes: Machine inputs pass a three-stage filter first.
// Notes: Input-to-output waits allow for that filter.
`timescale 1ns/1ps
module alrss_asserts (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic run_request_relay_in,
	input wire logic halt_in,
	input wire logic estop_closed_in,
	input wire logic shear_complete_in,
	input wire logic run_out,
	input wire logic forward_out,
	input wire logic slow_out,
	input wire logic reverse_out,
	input wire logic shear_down_out,
	input wire logic shear_up_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence estop_open;
		!estop_closed_in [*6];
	endsequence
	sequence halt_held;
		halt_in [*6];
	endsequence
	sequence cut_held;
		(shear_down_out && shear_complete_in) [*8];
	endsequence
	rev_only_jog_a: assert property (reverse_out |-> slow_out && !forward_out && !run_out)
		else $error("reverse with other outputs");
	run_is_fwd_a: assert property (run_out |-> forward_out)
		else $error("run without forward");
	slow_off_fast_a: assert property ($fell(slow_out) |-> forward_out && run_out)
		else $error("slow dropped outside run fast");
	estop_drops_a: assert property (estop_open |-> !run_out)
		else $error("run held in emergency stop");
	halt_drops_a: assert property (halt_held |-> !run_out)
		else $error("run held during halt");
	run_start_a: assert property ($rose(run_out) |-> $past(run_request_relay_in, 3))
		else $error("run rose without request");
	early_end_a: assert property (not cut_held)
		else $error("down held after complete");
	shear_excl_a: assert property (!(shear_down_out && shear_up_out))
		else $error("down and up together");
	up_after_down_a: assert property ($rose(shear_up_out) |->
		$past(shear_down_out) || $past(shear_down_out, 2))
		else $error("up without preceding down");
endmodule : alrss_asserts

bind alrss_sequencer alrss_asserts u_chk (.*);

// ### verification/alrss_machine_model.sv
// Purpose: Press model with a complete switch.
// Assumes: The switch closes a set time into the down stroke.
// Notes: It stays closed until the press is back up.
`timescale 1ns/1ps
module alrss_machine_model (
	input wire logic clk_in,
	input wire logic shear_down_in,
	input wire logic shear_up_in,
	input wire logic [7:0] dly_in,
	output logic cpl_out
);
	logic [7:0] cnt_q = 8'h00;
	initial cpl_out = 1'h0;
	always @(posedge clk_in) begin
		cnt_q <= shear_down_in ? cnt_q + 8'h01 : 8'h00;
		// A zero delay models a broken switch that never closes.
		if (!shear_down_in && !shear_up_in) cpl_out <= 1'h0;
		else if (dly_in != 8'h00 && cnt_q == dly_in) cpl_out <= 1'h1;
	end
endmodule : alrss_machine_model

// ### verification/tb_aux_line_run_shear_sequencer.sv
// Purpose: Self-checking bench for the run and shear sequencer.
// Assumes: Short dwell steps of four cycles.
// Notes: Bus results are queued and checked by a monitor.
`timescale 1ns/1ps
module tb_aux_line_run_shear_sequencer;
	import alrss_pkg::*;
	localparam logic [8:0] TC [6] = '{9'h101, 9'h181, 9'h121, 9'h141, 9'h101, 9'h103};
	localparam logic [3:0] TE [6] = '{4'h9, 4'hD, 4'hC, 4'h6, 4'h4, 4'h9};
	localparam logic [5:0] TR = 6'h23;
	logic clk_in = 1'h0;
	logic reset_n_in = 1'h0;
	logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00, cpl_dly = 8'h00;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hF;
	logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
	logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, halt_in = 1'h0;
	logic run_request_relay_in = 1'h0, estop_closed_in = 1'h1;
	logic pos_pulse_in = 1'h0, pos_reverse_in = 1'h0;
	logic unit_select_bit0_in = 1'h0, unit_select_bit1_in = 1'h0, unit_select_bit2_in = 1'h0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, run_out, forward_out, slow_out, reverse_out, shear_down_out;
	logic shear_up_out, die_boost_out, drive_enable_out, irq_out, shear_complete_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [67:0] exp_q [$];
	logic [67:0] x;
	int miscompares = 0;
	int checked = 0;
	always #12.5 clk_in = ~clk_in;
	alrss_sequencer #(.STEP_CYCLES(4), .TIMEOUT_STEPS(20)) DUT (.*);
	alrss_machine_model u_mach (.clk_in, .shear_down_in(shear_down_out),
		.shear_up_in(shear_up_out), .dly_in(cpl_dly), .cpl_out(shear_complete_in));
	task automatic give_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic cmp_bus(input logic [33:0] g, input logic [33:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected bus at %0t: got %h exp %h", $time, g, e);
		end
	endtask : cmp_bus
	task automatic cmp_pin(input logic [3:0] g, input logic [3:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected pins at %0t: got %h exp %h", $time, g, e);
		end
	endtask : cmp_pin
	// The monitor reads pre-edge values, so a handshake is seen at its own edge.
	always @(posedge clk_in) begin
		if ((s_axi_rvalid_out & s_axi_rready_in) === 1'h1) begin
			x = exp_q.pop_front();
			cmp_bus({s_axi_rresp_out, s_axi_rdata_out} & x[67:34], x[33:0]);
		end else if ((s_axi_bvalid_out & s_axi_bready_in) === 1'h1) begin
			x = exp_q.pop_front();
			cmp_bus({s_axi_bresp_out, 32'h0}, x[33:0]);
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({34'h0, r, 32'h0});
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			if (s_axi_awready_out === 1'h1) s_axi_awvalid_in <= 1'h0;
			if (s_axi_wready_out === 1'h1) s_axi_wvalid_in <= 1'h0;
		end while (s_axi_bvalid_out !== 1'h1);
		s_axi_bready_in <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
		exp_q.push_back({m, e});
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			if (s_axi_arready_out === 1'h1) s_axi_arvalid_in <= 1'h0;
		end while (s_axi_rvalid_out !== 1'h1);
		s_axi_rready_in <= 1'h0;
	endtask : rd
	task automatic start_run();
		run_request_relay_in <= 1'h1;
		cyc(8);
		run_request_relay_in <= 1'h0;
		cyc(8);
	endtask : start_run
	task automatic halt();
		halt_in <= 1'h1;
		cyc(8);
		halt_in <= 1'h0;
		cyc(8);
	endtask : halt
	task automatic enc(input int n, input logic rev);
		pos_reverse_in <= rev;
		repeat (n) begin
			cyc(4);
			pos_pulse_in <= 1'h1;
			cyc(4);
			pos_pulse_in <= 1'h0;
		end
	endtask : enc
	// Counts output cycles over a window longer than any programmed cycle here.
	task automatic shear(input logic [31:0] c, output int dn, output int up, output logic bo);
		dn = 0;
		up = 0;
		bo = 1'h0;
		wr(OFS_CTRL, c | 32'h1000, RESP_OKAY);
		repeat (300) begin
			@(posedge clk_in);
			dn += int'(shear_down_out);
			up += int'(shear_up_out);
			bo |= die_boost_out;
		end
	endtask : shear
	initial begin
		repeat (20000) @(posedge clk_in);
		miscompares++;
		give_verdict();
	end
	initial begin
		int i, n, m, dd, du, dn, up;
		logic bo;
		void'($urandom(32'h887C6667));
		cyc(4);
		reset_n_in <= 1'h1;
		cyc(8);
		for (i = 0; i < 8; i++) begin
			{unit_select_bit2_in, unit_select_bit1_in, unit_select_bit0_in} <= i[2:0];
			cyc(6);
			rd(OFS_UNIT, {RESP_OKAY, 17'h0, i[2:0], DEVICE_BASE + 4'(i), UNIT_BASE + 8'(i)},
				'1);
		end
		rd(8'h24, {RESP_SLVERR, 32'h0}, '1);
		wr(8'h24, 32'h1, RESP_SLVERR);
		rd(OFS_DWELL_DOWN, {RESP_OKAY, 32'h64}, '1);
		$display("test unit done");
		wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
		rd(OFS_IRQ_STAT, {RESP_OKAY, 32'h4}, {2'h3, 32'h1F});
		wr(OFS_CTRL, 32'h100, RESP_OKAY);
		start_run();
		cmp_pin(run_out, 1'h0);
		wr(OFS_CTRL, 32'h101, RESP_OKAY);
		start_run();
		cmp_pin({run_out, irq_out, drive_enable_out}, 3'h7);
		rd(OFS_IRQ_STAT, {RESP_OKAY, 32'h1}, {2'h3, 32'h1});
		cyc(3);
		cmp_pin(irq_out, 1'h0);
		wr(OFS_CTRL, 32'h2101, RESP_OKAY);
		cyc(2);
		cmp_pin(run_out, 1'h0);
		$display("test run done");
		for (i = 0; i < 6; i++) begin
			wr(OFS_CTRL, TC[i], RESP_OKAY);
			if (TR[i]) start_run();
			cyc(8);
			cmp_pin({forward_out, slow_out, reverse_out, run_out}, TE[i]);
			halt();
			wr(OFS_CTRL, 32'h101, RESP_OKAY);
		end
		$display("test outputs done");
		n = $urandom_range(6, 3);
		m = $urandom_range(2, 0);
		rd(OFS_POSITION, {RESP_OKAY, 32'h0}, {2'h3, 32'hFFFF});
		start_run();
		estop_closed_in <= 1'h0;
		enc(n, 1'h0);
		enc(m, 1'h1);
		cmp_pin(run_out, 1'h0);
		rd(OFS_POSITION, {RESP_OKAY, 32'(n - m)}, {2'h3, 32'hFFFF});
		estop_closed_in <= 1'h1;
		cyc(8);
		start_run();
		cmp_pin(run_out, 1'h1);
		halt();
		$display("test estop done");
		dd = $urandom_range(6, 4);
		du = $urandom_range(4, 2);
		wr(OFS_DWELL_DOWN, dd, RESP_OKAY);
		wr(OFS_DWELL_UP, du, RESP_OKAY);
		shear(32'h119, dn, up, bo);
		cmp_pin({dn >= 4 * dd && dn <= 4 * dd + 2, bo}, 2'h3);
		cmp_pin(up >= 4 * du && up <= 4 * du + 2, 1'h1);
		cpl_dly <= 8'h03;
		shear(32'h11D, dn, up, bo);
		cmp_pin({dn < 4 * dd, bo}, 2'h2);
		cmp_pin(up >= 4 * du && up <= 4 * du + 2, 1'h1);
		cpl_dly <= 8'h00;
		$display("test shear done");
		wr(OFS_DWELL_DOWN, 32'h0, RESP_OKAY);
		wr(OFS_CTRL, 32'h101, RESP_OKAY);
		start_run();
		shear(32'h101, dn, up, bo);
		cmp_pin({run_out, drive_enable_out}, 2'h0);
		start_run();
		cmp_pin(run_out, 1'h0);
		$display("test zero dwell done");
		give_verdict();
	end
endmodule : tb_aux_line_run_shear_sequencer
